/* logic/tsrb_consts.vh */
/*
 * Constants of the stream ring buffer pointer block: register offsets,
 * field positions, reset values and the address step.
 * Assumes a 12-bit byte address on the register port and 32-bit words.
 */
// Summary of operation
// - Each write channel pulses an event and sets a sticky flag when its present address reaches its read pointer minus its distance.
// - Start, end, pointer and distance registers keep bits 2 to 0 at zero, and software writes them 8-byte aligned.
// - Each write channel shows the address its next word goes to in a readable present-address register.
// - The read channel fetches only while its enable bit 0 is 1.
// - The read channel's buffer lies between a 32-bit start address and a 32-bit end address.
// - The read channel stops when its address reaches the write pointer and resumes only after a pointer update and reactivation.
// - The read channel pulses an event and sets a sticky flag when its address reaches the write pointer minus its distance.
// - The read channel's fetch address is readable in a read-only present-address register.
// - Each write channel stops when its address reaches the read pointer and resumes only after a pointer update and reactivation.
// - Write channel 7 takes unmatched stream data and may run in bypass mode; channels 0 to 6 also need their own filter enabled.
`ifndef TSRB_CONSTS_VH
`define TSRB_CONSTS_VH
`define TSRB_OFS_WR_CTRL    12'h000
`define TSRB_OFS_STATUS     12'h004
`define TSRB_OFS_WR_BASE    12'h040
`define TSRB_WR_CHAN_SHIFT  5
`define TSRB_SUB_START      3'h0
`define TSRB_SUB_END        3'h1
`define TSRB_SUB_RDPTR      3'h2
`define TSRB_SUB_DIST       3'h3
`define TSRB_SUB_PRESENT    3'h4
`define TSRB_OFS_RD_CTRL    12'h200
`define TSRB_OFS_RD_START   12'h204
`define TSRB_OFS_RD_END     12'h208
`define TSRB_OFS_RD_WRPTR   12'h20C
`define TSRB_OFS_RD_DIST    12'h210
`define TSRB_OFS_RD_PRESENT 12'h214
`define TSRB_WR_EN_STRIDE   4
`define TSRB_ST_RD_NEAR     8
`define TSRB_ST_WR_STALL    16
`define TSRB_ST_RD_STALL    24
`define TSRB_ADDR_STEP      32'h0000_0008
`define TSRB_ALIGN_MASK     32'hFFFF_FFF8
`define TSRB_RESET_WORD     32'h0000_0000
`define TSRB_FIFO_DEPTH     8
`define TSRB_UNMATCHED_CHAN 3'h7
`endif

/* logic/tsrb_top.v */
/*
 * Ring buffer pointer logic: eight write channels that store received
 * stream words into memory, one read channel that fetches words back out,
 * an 8-word FIFO in the received data's path, and the register port.
 * Assumes memory answers writes with a ready and reads with a one-cycle
 * acknowledge that carries the data, and that packet filtering upstream
 * supplies the channel number of each word.
 */
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tsrb_consts.vh"

module tsrb_fifo #(
	parameter W = 67,
	parameter D = 8,
	parameter AW = 3
) (
	input  wire          clk_i,
	input  wire          srst_i,
	input  wire [W-1:0]  in_data_i,
	input  wire          in_valid_i,
	output reg           in_ready_o,
	output wire [W-1:0]  out_data_o,
	output wire          out_valid_o,
	input  wire          out_ready_i
);
	reg [W-1:0]  mem [0:D-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0]   count_ff;
	wire         push;
	wire         pop;
	reg [AW:0]   nxt_count;

	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	assign out_valid_o = (count_ff != {(AW+1){1'b0}});
	assign out_data_o = mem[rd_ptr_ff];

	always @*
	begin
		nxt_count = count_ff;
		if (push & ~pop)
			nxt_count = count_ff + 1'b1;
		else if (pop & ~push)
			nxt_count = count_ff - 1'b1;
	end

	always @(posedge clk_i)
	begin
		if (push)
			mem[wr_ptr_ff] <= in_data_i;
		if (srst_i)
		begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			count_ff <= {(AW+1){1'b0}};
			in_ready_o <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			count_ff <= nxt_count;
			// Full is known one cycle ahead, so ready stays a plain flop.
			in_ready_o <= (nxt_count != D[AW:0]);
		end
	end
endmodule // tsrb_fifo

module tsrb_top (
	input  wire        SYS_CLK_I,
	input  wire        SRST_I,
	input  wire [11:0] REG_ADDR_I,
	input  wire [31:0] REG_WDATA_I,
	input  wire        REG_WR_I,
	input  wire        REG_RD_I,
	output reg  [31:0] REG_RDATA_O,
	input  wire [6:0]  FILTER_EN_I,
	input  wire        BYPASS_I,
	input  wire [63:0] STRM_DATA_I,
	input  wire [2:0]  STRM_CHAN_I,
	input  wire        STRM_VALID_I,
	output wire        STRM_READY_O,
	output reg  [31:0] MEM_WR_ADDR_O,
	output reg  [63:0] MEM_WR_DATA_O,
	output reg         MEM_WR_VALID_O,
	input  wire        MEM_WR_READY_I,
	output reg  [31:0] MEM_RD_ADDR_O,
	output reg         MEM_RD_REQ_O,
	input  wire        MEM_RD_ACK_I,
	input  wire [63:0] MEM_RD_DATA_I,
	output reg  [63:0] TX_DATA_O,
	output reg         TX_VALID_O,
	output reg  [7:0]  WR_NEAR_PULSE_O,
	output reg         RD_NEAR_PULSE_O
);
	reg [31:0] w_start_ff [0:7];
	reg [31:0] w_end_ff [0:7];
	reg [31:0] w_rdptr_ff [0:7];
	reg [31:0] w_dist_ff [0:7];
	reg [31:0] w_present_ff [0:7];
	reg [7:0]  w_en_ff;
	reg [7:0]  w_stall_ff;
	reg [7:0]  w_near_ff;
	reg        r_en_ff;
	reg [31:0] r_start_ff;
	reg [31:0] r_end_ff;
	reg [31:0] r_wrptr_ff;
	reg [31:0] r_dist_ff;
	reg [31:0] r_present_ff;
	reg        r_stall_ff;
	reg        r_near_ff;
	reg [31:0] rdata;
	reg [31:0] w_next;
	reg [31:0] r_next;
	reg        head_live;
	reg [2:0]  head_chan;
	wire [66:0] fifo_out;
	wire       fifo_valid;
	wire       head_go;
	wire       fifo_pop;
	wire       wr_sel;
	wire [11:0] wr_rel;
	wire [2:0] wr_chan;
	wire [2:0] wr_sub;
	wire [31:0] wdata_al;
	integer    i;
	integer    k;

	assign wr_sel = (REG_ADDR_I >= `TSRB_OFS_WR_BASE) & (REG_ADDR_I < `TSRB_OFS_RD_CTRL);
	assign wr_rel = REG_ADDR_I - `TSRB_OFS_WR_BASE;
	assign wr_chan = wr_rel[`TSRB_WR_CHAN_SHIFT+2:`TSRB_WR_CHAN_SHIFT];
	assign wr_sub = REG_ADDR_I[4:2];
	assign wdata_al = REG_WDATA_I & `TSRB_ALIGN_MASK;

	tsrb_fifo #(
		.W  (67),
		.D  (`TSRB_FIFO_DEPTH),
		.AW (3)
	) u_fifo (
		.clk_i       (SYS_CLK_I),
		.srst_i      (SRST_I),
		.in_data_i   ({STRM_CHAN_I, STRM_DATA_I}),
		.in_valid_i  (STRM_VALID_I),
		.in_ready_o  (STRM_READY_O),
		.out_data_o  (fifo_out),
		.out_valid_o (fifo_valid),
		.out_ready_i (fifo_pop)
	);
	// A stalled channel holds its word at the FIFO head, so the stall backs
	// up into the stream source; a word for a dead channel is dropped.
	always @*
	begin
		head_chan = BYPASS_I ? `TSRB_UNMATCHED_CHAN : fifo_out[66:64];
		head_live = w_en_ff[head_chan] &
			((head_chan == `TSRB_UNMATCHED_CHAN) | FILTER_EN_I[head_chan[2:0]]);
		w_next = w_present_ff[head_chan] + `TSRB_ADDR_STEP;
		if (w_next > w_end_ff[head_chan])
			w_next = w_start_ff[head_chan];
		r_next = r_present_ff + `TSRB_ADDR_STEP;
		if (r_next > r_end_ff)
			r_next = r_start_ff;
	end
	assign head_go = fifo_valid & ~MEM_WR_VALID_O & head_live & ~w_stall_ff[head_chan];
	assign fifo_pop = head_go | (fifo_valid & ~head_live);
	always @*
	begin
		rdata = `TSRB_RESET_WORD;
		if (wr_sel)
		begin
			case (wr_sub)
				`TSRB_SUB_START:   rdata = w_start_ff[wr_chan];
				`TSRB_SUB_END:     rdata = w_end_ff[wr_chan];
				`TSRB_SUB_RDPTR:   rdata = w_rdptr_ff[wr_chan];
				`TSRB_SUB_DIST:    rdata = w_dist_ff[wr_chan];
				`TSRB_SUB_PRESENT: rdata = w_present_ff[wr_chan];
				default:           rdata = `TSRB_RESET_WORD;
			endcase
		end
		else
		begin
			case (REG_ADDR_I)
				`TSRB_OFS_WR_CTRL:
					for (k = 0; k < 8; k = k + 1)
						rdata[k*`TSRB_WR_EN_STRIDE] = w_en_ff[k];
				`TSRB_OFS_STATUS:
					rdata = {7'h00, r_stall_ff, w_stall_ff, 7'h00, r_near_ff, w_near_ff};
				`TSRB_OFS_RD_CTRL:    rdata = {31'h0000_0000, r_en_ff};
				`TSRB_OFS_RD_START:   rdata = r_start_ff;
				`TSRB_OFS_RD_END:     rdata = r_end_ff;
				`TSRB_OFS_RD_WRPTR:   rdata = r_wrptr_ff;
				`TSRB_OFS_RD_DIST:    rdata = r_dist_ff;
				`TSRB_OFS_RD_PRESENT: rdata = r_present_ff;
				default:              rdata = `TSRB_RESET_WORD;
			endcase
		end
	end

	always @(posedge SYS_CLK_I)
	begin
		if (SRST_I)
		begin
			for (i = 0; i < 8; i = i + 1)
			begin
				w_start_ff[i] <= `TSRB_RESET_WORD;
				w_end_ff[i] <= `TSRB_RESET_WORD;
				w_rdptr_ff[i] <= `TSRB_RESET_WORD;
				w_dist_ff[i] <= `TSRB_RESET_WORD;
				w_present_ff[i] <= `TSRB_RESET_WORD;
			end
			w_en_ff <= 8'h00;
			w_stall_ff <= 8'h00;
			w_near_ff <= 8'h00;
			r_en_ff <= 1'b0;
			r_start_ff <= `TSRB_RESET_WORD;
			r_end_ff <= `TSRB_RESET_WORD;
			r_wrptr_ff <= `TSRB_RESET_WORD;
			r_dist_ff <= `TSRB_RESET_WORD;
			r_present_ff <= `TSRB_RESET_WORD;
			r_stall_ff <= 1'b0;
			r_near_ff <= 1'b0;
			REG_RDATA_O <= `TSRB_RESET_WORD;
			MEM_WR_ADDR_O <= `TSRB_RESET_WORD;
			MEM_WR_DATA_O <= 64'h0000_0000_0000_0000;
			MEM_WR_VALID_O <= 1'b0;
			MEM_RD_ADDR_O <= `TSRB_RESET_WORD;
			MEM_RD_REQ_O <= 1'b0;
			TX_DATA_O <= 64'h0000_0000_0000_0000;
			TX_VALID_O <= 1'b0;
			WR_NEAR_PULSE_O <= 8'h00;
			RD_NEAR_PULSE_O <= 1'b0;
		end
		else
		begin
			REG_RDATA_O <= REG_RD_I ? rdata : `TSRB_RESET_WORD;
			WR_NEAR_PULSE_O <= 8'h00;
			RD_NEAR_PULSE_O <= 1'b0;
			TX_VALID_O <= 1'b0;
			// Register writes come first so that hardware events below win.
			if (REG_WR_I)
			begin
				if (wr_sel)
				begin
					case (wr_sub)
						`TSRB_SUB_START: w_start_ff[wr_chan] <= wdata_al;
						`TSRB_SUB_END:   w_end_ff[wr_chan] <= wdata_al;
						`TSRB_SUB_RDPTR: w_rdptr_ff[wr_chan] <= wdata_al;
						`TSRB_SUB_DIST:  w_dist_ff[wr_chan] <= wdata_al;
						default:         w_en_ff <= w_en_ff;
					endcase
				end
				else
				begin
					case (REG_ADDR_I)
						`TSRB_OFS_WR_CTRL:
						begin
							for (i = 0; i < 8; i = i + 1)
							begin
								w_en_ff[i] <= REG_WDATA_I[i*`TSRB_WR_EN_STRIDE];
								// Enabling a disabled channel starts it at its start address.
								if (REG_WDATA_I[i*`TSRB_WR_EN_STRIDE] & ~w_en_ff[i])
								begin
									w_present_ff[i] <= w_start_ff[i];
									w_stall_ff[i] <= 1'b0;
								end
								// Reactivation releases a stall only once the pointer has moved.
								if (REG_WDATA_I[i*`TSRB_WR_EN_STRIDE] &
									(w_rdptr_ff[i] != w_present_ff[i]))
									w_stall_ff[i] <= 1'b0;
							end
						end
						`TSRB_OFS_STATUS:
						begin
							w_near_ff <= w_near_ff & ~REG_WDATA_I[7:0];
							if (REG_WDATA_I[`TSRB_ST_RD_NEAR])
								r_near_ff <= 1'b0;
						end
						`TSRB_OFS_RD_CTRL:
						begin
							r_en_ff <= REG_WDATA_I[0];
							if (REG_WDATA_I[0] & ~r_en_ff)
							begin
								r_present_ff <= r_start_ff;
								r_stall_ff <= 1'b0;
							end
							if (REG_WDATA_I[0] & (r_wrptr_ff != r_present_ff))
								r_stall_ff <= 1'b0;
						end
						`TSRB_OFS_RD_START: r_start_ff <= wdata_al;
						`TSRB_OFS_RD_END:   r_end_ff <= wdata_al;
						`TSRB_OFS_RD_WRPTR: r_wrptr_ff <= wdata_al;
						`TSRB_OFS_RD_DIST:  r_dist_ff <= wdata_al;
						default:            r_en_ff <= r_en_ff;
					endcase
				end
			end
			if (MEM_WR_VALID_O & MEM_WR_READY_I)
				MEM_WR_VALID_O <= 1'b0;
			if (head_go)
			begin
				MEM_WR_ADDR_O <= w_present_ff[head_chan];
				MEM_WR_DATA_O <= fifo_out[63:0];
				MEM_WR_VALID_O <= 1'b1;
				w_present_ff[head_chan] <= w_next;
				if (w_next == w_rdptr_ff[head_chan])
					w_stall_ff[head_chan] <= 1'b1;
				if (w_next == w_rdptr_ff[head_chan] - w_dist_ff[head_chan])
				begin
					w_near_ff[head_chan] <= 1'b1;
					WR_NEAR_PULSE_O[head_chan] <= 1'b1;
				end
			end
			// The request is held until the acknowledge, one word at a time.
			if (MEM_RD_REQ_O & MEM_RD_ACK_I)
			begin
				MEM_RD_REQ_O <= 1'b0;
				TX_DATA_O <= MEM_RD_DATA_I;
				TX_VALID_O <= 1'b1;
				r_present_ff <= r_next;
				if (r_next == r_wrptr_ff)
					r_stall_ff <= 1'b1;
				if (r_next == r_wrptr_ff - r_dist_ff)
				begin
					r_near_ff <= 1'b1;
					RD_NEAR_PULSE_O <= 1'b1;
				end
			end
			else if (~MEM_RD_REQ_O & r_en_ff & ~r_stall_ff)
			begin
				MEM_RD_REQ_O <= 1'b1;
				MEM_RD_ADDR_O <= r_present_ff;
			end
		end
	end
endmodule // tsrb_top
`default_nettype wire

/* test/tsrb_mem_model.sv */
/*
 * Memory model for the bus side: logs accepted writes, answers reads.
 * Read data is derived from the address; slow mode stretches handshakes.
 */
`timescale 1ns/1ps
`default_nettype none
module tsrb_mem_model (
	input wire logic        clk_i,
	input wire logic        slow_i,
	input wire logic [31:0] wr_addr_i,
	input wire logic [63:0] wr_data_i,
	input wire logic        wr_valid_i,
	input wire logic [31:0] rd_addr_i,
	input wire logic        rd_req_i,
	output var logic        wr_ready_o,
	output var logic        rd_ack_o,
	output var logic [63:0] rd_data_o
);
	logic        hold;
	logic [95:0] wq[$];
	initial
	begin
		hold = 1'b0;
		wr_ready_o = 1'b0;
		rd_ack_o = 1'b0;
		rd_data_o = 64'h0000_0000_0000_0000;
	end
	// Idle read data toggles so a late sample never matches by chance.
	always @(posedge clk_i)
	begin
		hold <= slow_i && !hold;
		wr_ready_o <= !slow_i || !wr_ready_o;
		if (wr_valid_i && wr_ready_o)
			wq.push_back({wr_addr_i, wr_data_i});
		rd_ack_o <= rd_req_i && !rd_ack_o && !hold;
		if (rd_req_i && !rd_ack_o && !hold)
			rd_data_o <= {~rd_addr_i, rd_addr_i};
		else
			rd_data_o <= ~rd_data_o;
	end
endmodule // tsrb_mem_model
`default_nettype wire

/* test/tsrb_top_asserts.sv */
/*
 * Port checker for tsrb_top: memory handshakes, read data and event pulses.
 * Assumes one clock domain and the synchronous reset of the block.
 */
`timescale 1ns/1ps
`default_nettype none
module tsrb_top_asserts (
	input wire logic        SYS_CLK_I,
	input wire logic        SRST_I,
	input wire logic        REG_RD_I,
	input wire logic [31:0] REG_RDATA_O,
	input wire logic [31:0] MEM_WR_ADDR_O,
	input wire logic        MEM_WR_VALID_O,
	input wire logic        MEM_WR_READY_I,
	input wire logic [31:0] MEM_RD_ADDR_O,
	input wire logic        MEM_RD_REQ_O,
	input wire logic        MEM_RD_ACK_I,
	input wire logic [63:0] MEM_RD_DATA_I,
	input wire logic [63:0] TX_DATA_O,
	input wire logic        TX_VALID_O,
	input wire logic [7:0]  WR_NEAR_PULSE_O,
	input wire logic        RD_NEAR_PULSE_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (SRST_I);
	chk_rdata_idle: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0000_0000)
		else $error("read data not zero outside a read");
	chk_wr_hold: assert property (MEM_WR_VALID_O && !MEM_WR_READY_I |=>
		MEM_WR_VALID_O && $stable(MEM_WR_ADDR_O)) else $error("write dropped early");
	chk_wr_gap: assert property (MEM_WR_VALID_O && MEM_WR_READY_I |=> !MEM_WR_VALID_O)
		else $error("write valid without gap");
	chk_wr_align: assert property (MEM_WR_VALID_O |-> MEM_WR_ADDR_O[2:0] == 3'h0)
		else $error("write address not aligned");
	chk_rd_hold: assert property (MEM_RD_REQ_O && !MEM_RD_ACK_I |=>
		MEM_RD_REQ_O && $stable(MEM_RD_ADDR_O)) else $error("read request dropped early");
	chk_rd_gap: assert property (MEM_RD_REQ_O && MEM_RD_ACK_I |=> !MEM_RD_REQ_O)
		else $error("read request right after ack");
	chk_tx_data: assert property (MEM_RD_REQ_O && MEM_RD_ACK_I |=>
		TX_VALID_O && TX_DATA_O == $past(MEM_RD_DATA_I)) else $error("tx word wrong");
	chk_tx_cause: assert property (TX_VALID_O |-> $past(MEM_RD_REQ_O && MEM_RD_ACK_I))
		else $error("tx word without fetch");
	chk_rd_near: assert property (RD_NEAR_PULSE_O |-> TX_VALID_O ##1 !RD_NEAR_PULSE_O)
		else $error("read event pulse wrong");
	chk_wr_near: assert property (|WR_NEAR_PULSE_O |-> $rose(MEM_WR_VALID_O)
		##1 WR_NEAR_PULSE_O == 8'h00) else $error("write event pulse wrong");
	cover property (|WR_NEAR_PULSE_O);
	cover property (RD_NEAR_PULSE_O);
	cover property (MEM_WR_VALID_O && !MEM_WR_READY_I);
endmodule // tsrb_top_asserts
`default_nettype wire

/* test/tsrb_top_bench.sv */
/*
 * Self-checking bench for tsrb_top: registers, write channels, read channel.
 * Assumes the memory model on the bus side and a 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tsrb_top_bench;
	logic        SYS_CLK_I = 1'b0;
	logic        SRST_I = 1'b1;
	logic [11:0] REG_ADDR_I = 12'h000;
	logic [31:0] REG_WDATA_I = 32'h0000_0000;
	logic        REG_WR_I = 1'b0;
	logic        REG_RD_I = 1'b0;
	logic [6:0]  FILTER_EN_I = 7'h01;
	logic        BYPASS_I = 1'b0;
	logic [63:0] STRM_DATA_I = 64'h0000_0000_0000_0000;
	logic [2:0]  STRM_CHAN_I = 3'h0;
	logic        STRM_VALID_I = 1'b0;
	logic        STRM_READY_O, MEM_WR_VALID_O, MEM_WR_READY_I, MEM_RD_REQ_O;
	logic        MEM_RD_ACK_I, TX_VALID_O, RD_NEAR_PULSE_O;
	logic [31:0] REG_RDATA_O, MEM_WR_ADDR_O, MEM_RD_ADDR_O;
	logic [63:0] MEM_WR_DATA_O, MEM_RD_DATA_I, TX_DATA_O;
	logic [7:0]  WR_NEAR_PULSE_O;
	logic [63:0] tq[$];
	logic [11:0] al[8] = '{12'h204, 12'h208, 12'h20C, 12'h210, 12'h040, 12'h044, 12'h048, 12'h04C};
	logic [43:0] cfg[13] = '{44'h040_0000_1000, 44'h044_0000_1008, 44'h048_0000_1010,
		44'h04C_0000_0100, 44'h120_0000_2000, 44'h124_0000_2018, 44'h128_0000_2010,
		44'h12C_0000_0008, 44'h204_0000_3000, 44'h208_0000_3010, 44'h20C_0000_3010,
		44'h210_0000_0008, 44'h000_1000_0011};
	logic [47:0] wexp[6] = '{48'h1000_0000_00A0, 48'h1008_0000_00A2, 48'h1000_0000_00A3,
		48'h2000_0000_00B0, 48'h2008_0000_00B1, 48'h2010_0000_00B2};
	logic [31:0] ra[4] = '{32'h0000_3000, 32'h0000_3008, 32'h0000_3010, 32'h0000_3000};
	int          errors = 0;
	int          check_count = 0;
	int          wpc = 0;
	int          rpc = 0;
	tsrb_top DUT (.*);
	tsrb_mem_model mem (.clk_i(SYS_CLK_I), .slow_i(1'b1), .wr_addr_i(MEM_WR_ADDR_O),
		.wr_data_i(MEM_WR_DATA_O), .wr_valid_i(MEM_WR_VALID_O), .rd_addr_i(MEM_RD_ADDR_O),
		.rd_req_i(MEM_RD_REQ_O), .wr_ready_o(MEM_WR_READY_I), .rd_ack_o(MEM_RD_ACK_I),
		.rd_data_o(MEM_RD_DATA_I));
	always #10 SYS_CLK_I = ~SYS_CLK_I;
	always @(posedge SYS_CLK_I)
	begin
		if (TX_VALID_O === 1'b1) tq.push_back(TX_DATA_O);
		if (RD_NEAR_PULSE_O === 1'b1) rpc++;
		// Only channel 7 ever comes near; any other event bit weighs heavily.
		if (!SRST_I && WR_NEAR_PULSE_O !== 8'h00) wpc += (WR_NEAR_PULSE_O === 8'h80) ? 1 : 100;
	end
	task automatic chk(input logic [95:0] got, input logic [95:0] exp);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		REG_ADDR_I <= a;
		REG_WDATA_I <= d;
		REG_WR_I <= 1'b1;
		@(posedge SYS_CLK_I);
		REG_WR_I <= 1'b0;
		@(posedge SYS_CLK_I);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		REG_ADDR_I <= a;
		REG_RD_I <= 1'b1;
		@(posedge SYS_CLK_I);
		REG_RD_I <= 1'b0;
		@(posedge SYS_CLK_I);
		chk(REG_RDATA_O, e);
	endtask
	task automatic send(input logic [2:0] c, input logic [63:0] d);
		STRM_CHAN_I <= c;
		STRM_DATA_I <= d;
		STRM_VALID_I <= 1'b1;
		@(posedge SYS_CLK_I);
		while (STRM_READY_O !== 1'b1) @(posedge SYS_CLK_I);
		STRM_VALID_I <= 1'b0;
		@(posedge SYS_CLK_I);
	endtask
	// Bounded wait so a stuck channel ends in a count mismatch, not a hang.
	task automatic waitn(input int n, input bit txq);
		repeat (300) if ((txq ? tq.size() : mem.wq.size()) < n) @(posedge SYS_CLK_I);
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#200_000;
		errors++;
		$display("watchdog expired");
		conclude();
	end
	initial
	begin
		repeat (6) @(posedge SYS_CLK_I);
		SRST_I <= 1'b0;
		@(posedge SYS_CLK_I);
		rd(12'h04C, 32'h0000_0000);
		rd(12'h3F0, 32'h0000_0000);
		foreach (al[i])
		begin
			wr(al[i], 32'hFFFF_FFFF);
			rd(al[i], 32'hFFFF_FFF8);
		end
		wr(12'h214, 32'h1234_5678);
		rd(12'h214, 32'h0000_0000);
		wr(12'h050, 32'h1234_5678);
		rd(12'h050, 32'h0000_0000);
		$display("test registers done");
		foreach (cfg[i]) wr(cfg[i][43:32], cfg[i][31:0]);
		send(3'h0, 64'hA0);
		send(3'h1, 64'hA1);
		send(3'h0, 64'hA2);
		send(3'h0, 64'hA3);
		waitn(3, 1'b0);
		BYPASS_I <= 1'b1;
		send(3'h3, 64'hB0);
		send(3'h5, 64'hB1);
		send(3'h2, 64'hB2);
		waitn(5, 1'b0);
		repeat (20) @(posedge SYS_CLK_I);
		chk(mem.wq.size(), 5);
		rd(12'h004, 32'h0080_0080);
		rd(12'h130, 32'h0000_2010);
		rd(12'h050, 32'h0000_1008);
		wr(12'h128, 32'h0000_2000);
		wr(12'h000, 32'h1000_0011);
		waitn(6, 1'b0);
		foreach (wexp[i]) chk(mem.wq[i], {wexp[i][47:32], 16'h0000, 16'h0000, wexp[i][31:0]});
		rd(12'h130, 32'h0000_2018);
		chk(wpc, 1);
		$display("test write channels done");
		repeat (10) @(posedge SYS_CLK_I);
		chk(tq.size(), 0);
		wr(12'h200, 32'h0000_0001);
		waitn(2, 1'b1);
		repeat (20) @(posedge SYS_CLK_I);
		chk(tq.size(), 2);
		rd(12'h004, 32'h0100_0180);
		rd(12'h214, 32'h0000_3010);
		wr(12'h004, 32'h0000_0180);
		rd(12'h004, 32'h0100_0000);
		wr(12'h20C, 32'h0000_3008);
		wr(12'h200, 32'h0000_0001);
		waitn(4, 1'b1);
		foreach (ra[i]) chk(tq[i], {~ra[i], ra[i]});
		rd(12'h214, 32'h0000_3008);
		chk(rpc, 2);
		$display("test read channel done");
		conclude();
	end
endmodule // tsrb_top_bench
bind tsrb_top tsrb_top_asserts chk_u (.*);
`default_nettype wire
